/* common/ddcr_defines.svh */
`ifndef DDCR_DEFINES_SVH
`define DDCR_DEFINES_SVH

// Register offsets (byte addresses within the page)
`define DDCR_OFF_BYTE_LOW 4'hc
`define DDCR_OFF_BYTE_MID 4'hd
`define DDCR_OFF_BYTE_HIGH 4'he
`define DDCR_OFF_COMMAND 4'hf

// Command register bit positions
`define DDCR_CMD_SELECT 7
`define DDCR_CMD_LATCH 6
`define DDCR_CMD_GATE_OFF 5
`define DDCR_CMD_GATE_ON 4
`define DDCR_CMD_STOP 3
`define DDCR_CMD_RUN 2
`define DDCR_CMD_LOAD 1
`define DDCR_CMD_ZERO 0

// Reset values
`define DDCR_RST_BYTE 8'h00
`define DDCR_RST_CNT0 24'h000000
`define DDCR_RST_CNT1 16'h0000

// Revision code, arbitrary neutral value
`define DDCR_REVISION 8'h5a

`endif

/* common/ddcr_pkg.sv */
package ddcr_pkg;
	// Command operations decoded from one write
	typedef enum logic [2:0] {
		DDCR_OP_NONE,
		DDCR_OP_LATCH,
		DDCR_OP_GATE_OFF,
		DDCR_OP_GATE_ON,
		DDCR_OP_STOP,
		DDCR_OP_RUN,
		DDCR_OP_LOAD,
		DDCR_OP_ZERO
	} ddcr_op_e;
	// Register data byte
	typedef logic [7:0] ddcr_byte_t;
endpackage : ddcr_pkg

/* logic/ddcr_in_sync.sv */
`timescale 1ns/1ps
`include "ddcr_defines.svh"

// Two-flop synchroniser with rising-edge pulse
module ddcr_in_sync (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Asynchronous input
	input wire logic async_in,
	// Synchronised level and rising edge
	output logic level_r,
	output logic rise_r
);
	logic meta_r; // First stage, read only by second
	logic sync_r; // Second stage
	logic prev_r; // Delayed copy for edge detect

	// Synchroniser chain and edge detect
	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
			level_r <= 1'b0;
			rise_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
			level_r <= sync_r;
			rise_r <= sync_r & ~prev_r;
		end
	end
endmodule : ddcr_in_sync

/* logic/ddcr_top.sv */
`timescale 1ns/1ps
`include "ddcr_defines.svh"
// Notes on behaviour
// - Low byte write fills holding only
// - Data reads return latched snapshot bytes
// - Middle byte is bits fifteen to eight
// - Counter 0 24 bits, counter 1 16
// - Counter 1 load ignores high byte
// - Bit 7 selects; one operation per write
// - Latch command snapshots selected counter
// - Counter 1 latch keeps high byte
// - Gate off command disables gating
// - Gate on: count only gate high
// - Stop command ignores input pulses
// - Run command decrements per pulse
// - Load command copies holding bytes
// - Zero command clears selected counter
// - Command offset reads revision code
module ddcr_top #(
	parameter int CNT0_W = 24,
	parameter int CNT1_W = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_r,
	// Counter pulse inputs
	input wire logic count_pulse_first,
	input wire logic count_pulse_second,
	// Gate inputs
	input wire logic gate_input_first,
	input wire logic gate_input_second,
	// Counter values
	output logic [CNT0_W-1:0] count0_r,
	output logic [CNT1_W-1:0] count1_r
);

	////////////////////////////////////////////////////////////////
	// Declarations
	////////////////////////////////////////////////////////////////
	// Host-written and latched byte storage
	ddcr_pkg::ddcr_byte_t hold_low_r; // Holding bytes
	ddcr_pkg::ddcr_byte_t hold_mid_r;
	ddcr_pkg::ddcr_byte_t hold_high_r;
	ddcr_pkg::ddcr_byte_t snap_low_r; // Latched readback bytes
	ddcr_pkg::ddcr_byte_t snap_mid_r;
	ddcr_pkg::ddcr_byte_t snap_high_r;
	// Per-counter control state
	logic gate_en0_r; // Gating enabled per counter
	logic gate_en1_r;
	logic run0_r; // Counting enabled per counter
	logic run1_r;
	// Synchronised pin inputs
	logic pulse0_rise; // Synchronised pulse edges
	logic pulse1_rise;
	logic gate_input_first_lvl; // Synchronised gate levels
	logic gate_input_second_lvl;
	// Command decode results
	logic cmd_wr; // Command write this cycle
	logic counter_select; // Selected counter
	ddcr_pkg::ddcr_op_e op; // Decoded operation
	logic step0; // Decrement qualifiers
	logic step1;

	// One-hot decode of the low seven command bits
	function automatic ddcr_pkg::ddcr_op_e decode_op(input logic [6:0] b);
		ddcr_pkg::ddcr_op_e r;
		r = ddcr_pkg::DDCR_OP_NONE;
		// Zero or several bits set give no operation
		case (b)
			7'h40: r = ddcr_pkg::DDCR_OP_LATCH;
			7'h20: r = ddcr_pkg::DDCR_OP_GATE_OFF;
			7'h10: r = ddcr_pkg::DDCR_OP_GATE_ON;
			7'h08: r = ddcr_pkg::DDCR_OP_STOP;
			7'h04: r = ddcr_pkg::DDCR_OP_RUN;
			7'h02: r = ddcr_pkg::DDCR_OP_LOAD;
			7'h01: r = ddcr_pkg::DDCR_OP_ZERO;
			default: r = ddcr_pkg::DDCR_OP_NONE;
		endcase
		return r;
	endfunction : decode_op

	// Pulse edge qualified by run and gating state
	function automatic logic step_ok(input logic rise, input logic run,
		input logic gate_en, input logic gate_lvl);
		logic ok;
		ok = rise && run;
		if (gate_en && !gate_lvl) begin
			ok = 1'b0;
		end
		return ok;
	endfunction : step_ok

	////////////////////////////////////////////////////////////////
	// Input synchronisers
	////////////////////////////////////////////////////////////////
	// pulse synchronisers
	// Counter 0 pulse input
	ddcr_in_sync u_pulse0 (
		.mclk(mclk),
		.rst(rst),
		.async_in(count_pulse_first),
		.level_r(),
		.rise_r(pulse0_rise)
	);
	// Counter 1 pulse input
	ddcr_in_sync u_pulse1 (
		.mclk(mclk),
		.rst(rst),
		.async_in(count_pulse_second),
		.level_r(),
		.rise_r(pulse1_rise)
	);
	// gate synchronisers
	// Counter 0 gate input
	ddcr_in_sync u_gate_input_first (
		.mclk(mclk),
		.rst(rst),
		.async_in(gate_input_first),
		.level_r(gate_input_first_lvl),
		.rise_r()
	);
	// Counter 1 gate input
	ddcr_in_sync u_gate_input_second (
		.mclk(mclk),
		.rst(rst),
		.async_in(gate_input_second),
		.level_r(gate_input_second_lvl),
		.rise_r()
	);

	////////////////////////////////////////////////////////////////
	// Command decode
	////////////////////////////////////////////////////////////////
	// select and one-hot op
	always_comb begin
		cmd_wr = reg_wr && (reg_addr == `DDCR_OFF_COMMAND);
		counter_select = reg_wdata[`DDCR_CMD_SELECT];
		// Malformed commands decode to no operation
		op = cmd_wr ? decode_op(reg_wdata[6:0]) : ddcr_pkg::DDCR_OP_NONE;
	end

	always_comb begin
		step0 = step_ok(pulse0_rise, run0_r, gate_en0_r, gate_input_first_lvl);
		step1 = step_ok(pulse1_rise, run1_r, gate_en1_r, gate_input_second_lvl);
	end

	////////////////////////////////////////////////////////////////
	// Holding bytes
	////////////////////////////////////////////////////////////////
	// writes fill holding only
	always_ff @(posedge mclk) begin
		if (rst) begin
			// Holding bytes start at zero
			hold_low_r <= `DDCR_RST_BYTE;
			hold_mid_r <= `DDCR_RST_BYTE;
			hold_high_r <= `DDCR_RST_BYTE;
		end else if (reg_wr) begin
			// Counter values are untouched by these writes
			case (reg_addr)
				`DDCR_OFF_BYTE_LOW: hold_low_r <= reg_wdata;
				`DDCR_OFF_BYTE_MID: hold_mid_r <= reg_wdata;
				`DDCR_OFF_BYTE_HIGH: hold_high_r <= reg_wdata;
				// Other offsets leave the holding bytes alone
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Latched snapshot
	////////////////////////////////////////////////////////////////
	// latch selected counter
	always_ff @(posedge mclk) begin
		if (rst) begin
			// Snapshot reads zero until first latch
			snap_low_r <= `DDCR_RST_BYTE;
			snap_mid_r <= `DDCR_RST_BYTE;
			snap_high_r <= `DDCR_RST_BYTE;
		end else if (op == ddcr_pkg::DDCR_OP_LATCH) begin
			// Counter values from before this edge
			if (counter_select) begin
				snap_low_r <= count1_r[7:0];
				snap_mid_r <= count1_r[15:8];
			end else begin
				snap_low_r <= count0_r[7:0];
				snap_mid_r <= count0_r[15:8];
				snap_high_r <= count0_r[23:16];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Gate and run enables
	////////////////////////////////////////////////////////////////
	// gate off, gate on
	always_ff @(posedge mclk) begin
		if (rst) begin
			// Gating off after reset
			gate_en0_r <= 1'b0;
			gate_en1_r <= 1'b0;
		end else if (op == ddcr_pkg::DDCR_OP_GATE_OFF) begin
			// Gate input ignored from the next cycle
			if (counter_select) gate_en1_r <= 1'b0;
			else gate_en0_r <= 1'b0;
		end else if (op == ddcr_pkg::DDCR_OP_GATE_ON) begin
			// Gate input qualifies pulses from now on
			if (counter_select) gate_en1_r <= 1'b1;
			else gate_en0_r <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			// Counting stopped after reset
			run0_r <= 1'b0;
			run1_r <= 1'b0;
		end else if (op == ddcr_pkg::DDCR_OP_STOP) begin
			// Edges already in the synchroniser are dropped
			if (counter_select) run1_r <= 1'b0;
			else run0_r <= 1'b0;
		end else if (op == ddcr_pkg::DDCR_OP_RUN) begin
			// Next qualified edge decrements
			if (counter_select) run1_r <= 1'b1;
			else run0_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Counters
	////////////////////////////////////////////////////////////////
	// Both counters share one priority: zero, load, step
	// counter 0, 24-bit down-counter
	always_ff @(posedge mclk) begin
		if (rst) begin
			// Counter 0 starts at zero
			count0_r <= `DDCR_RST_CNT0;
		end else if (!counter_select && op == ddcr_pkg::DDCR_OP_ZERO) begin
			count0_r <= `DDCR_RST_CNT0;
		end else if (!counter_select && op == ddcr_pkg::DDCR_OP_LOAD) begin
			count0_r <= {hold_high_r, hold_mid_r, hold_low_r};
		end else if (step0) begin
			// decrement on pulse
			// Wraps from zero to all ones
			count0_r <= count0_r - 24'h000001;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			// Counter 1 starts at zero
			count1_r <= `DDCR_RST_CNT1;
		end else if (counter_select && op == ddcr_pkg::DDCR_OP_ZERO) begin
			count1_r <= `DDCR_RST_CNT1;
		end else if (counter_select && op == ddcr_pkg::DDCR_OP_LOAD) begin
			count1_r <= {hold_mid_r, hold_low_r};
		end else if (step1) begin
			// decrement on pulse
			// Wraps from zero to all ones
			count1_r <= count1_r - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data
	////////////////////////////////////////////////////////////////
	// snapshot readback, revision
	always_ff @(posedge mclk) begin
		if (rst) begin
			// Bus reads zero in reset
			reg_rdata_r <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`DDCR_OFF_BYTE_LOW: reg_rdata_r <= snap_low_r;
				`DDCR_OFF_BYTE_MID: reg_rdata_r <= snap_mid_r;
				`DDCR_OFF_BYTE_HIGH: reg_rdata_r <= snap_high_r;
				`DDCR_OFF_COMMAND: reg_rdata_r <= `DDCR_REVISION;
				// Unmapped offsets read as zero
				default: reg_rdata_r <= 8'h00;
			endcase
		end else begin
			// Data stands for one cycle only
			reg_rdata_r <= 8'h00;
		end
	end

endmodule : ddcr_top

/* test/ddcr_chk.sv */
`timescale 1ns/1ps
`include "ddcr_defines.svh"
// Port checker for the counter block
module ddcr_chk #(
	parameter int CNT0_W = 24,
	parameter int CNT1_W = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_r,
	// Counter values
	input wire logic [CNT0_W-1:0] count0_r,
	input wire logic [CNT1_W-1:0] count1_r
);
	logic [23:0] hold_r; // Shadow of holding bytes
	logic [15:0] hold_lo; // Low two holding bytes
	logic cmd; // Command write this cycle
	assign cmd = reg_wr && reg_addr == 4'hf;
	assign hold_lo = hold_r[15:0];
	// Follow host writes into the holding bytes
	always_ff @(posedge mclk)
		if (rst) hold_r <= 24'h000000;
		else if (reg_wr && reg_addr == 4'hc) hold_r[7:0] <= reg_wdata;
		else if (reg_wr && reg_addr == 4'hd) hold_r[15:8] <= reg_wdata;
		else if (reg_wr && reg_addr == 4'he) hold_r[23:16] <= reg_wdata;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_rd_idle: assert property (
		!$past(reg_rd) |-> reg_rdata_r == 8'h00) else $error("rdata not idle");
	a_rev_read: assert property (
		reg_rd && reg_addr == 4'hf |=> reg_rdata_r == `DDCR_REVISION)
		else $error("bad revision");
	a_zero_c0: assert property (
		cmd && reg_wdata == 8'h01 |=> count0_r == 24'h000000)
		else $error("c0 not zeroed");
	a_zero_c1: assert property (
		cmd && reg_wdata == 8'h81 |=> count1_r == 16'h0000)
		else $error("c1 not zeroed");
	a_load_c0: assert property (
		cmd && reg_wdata == 8'h02 |=> count0_r == $past(hold_r))
		else $error("c0 bad load");
	a_load_c1: assert property (
		cmd && reg_wdata == 8'h82 |=> count1_r == $past(hold_lo))
		else $error("c1 bad load");
	a_stop_hold: assert property (
		cmd && reg_wdata == 8'h08 |=> $stable(count0_r) [*8])
		else $error("c0 moved when stopped");
	a_dec_c0: assert property (
		!$past(reg_wr) && count0_r != $past(count0_r)
		|-> count0_r == $past(count0_r) - 24'h000001) else $error("c0 step");
	a_dec_c1: assert property (
		!$past(reg_wr) && count1_r != $past(count1_r)
		|-> count1_r == $past(count1_r) - 16'h0001) else $error("c1 step");
endmodule : ddcr_chk
bind ddcr_top ddcr_chk #(.CNT0_W(CNT0_W), .CNT1_W(CNT1_W)) chk_i (
	.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
	.count0_r(count0_r), .count1_r(count1_r));

/* test/ddcr_host.sv */
`timescale 1ns/1ps
// Host side: byte register master
module ddcr_host (
	// Clock
	input wire logic mclk,
	// Register port
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata_r
);
	// Idle bus at time zero
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One-cycle write; released lines show inverted values
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
	endtask : wr
	// One-cycle read; data taken in the following cycle
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata_r;
	endtask : rd
endmodule : ddcr_host

/* test/ddcr_top_tb.sv */
`timescale 1ns/1ps
`include "ddcr_defines.svh"
// Self-checking bench for the counter block
module ddcr_top_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata_r;
	logic reg_wr;
	logic reg_rd;
	logic pls0 = 1'b0; // Pulse inputs
	logic pls1 = 1'b0;
	logic gt0 = 1'b0; // Gate inputs
	logic gt1 = 1'b0;
	logic [23:0] count0_r;
	logic [15:0] count1_r;
	int err_count = 0;
	int compares = 0;
	always #25 mclk = ~mclk;
	ddcr_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
	ddcr_top #(.CNT0_W(24), .CNT1_W(16)) uut (.mclk(mclk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.count_pulse_first(pls0), .count_pulse_second(pls1),
		.gate_input_first(gt0), .gate_input_second(gt1),
		.count0_r(count0_r), .count1_r(count1_r));
	// Value compare
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("Error %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Read compare
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk({16'h0000, d}, {16'h0000, e});
	endtask : rdc
	// Pulse one input k times, then let it settle
	task automatic pulse(input bit s, input int k);
		repeat (k) begin
			@(posedge mclk);
			pls0 <= !s;
			pls1 <= s;
			repeat (3) @(posedge mclk);
			pls0 <= 1'b0;
			pls1 <= 1'b0;
			repeat (3) @(posedge mclk);
		end
		repeat (6) @(posedge mclk);
	endtask : pulse
	task automatic finish_test;
		$display("err_count %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	// Load and latch counter 0
	task automatic t_load0;
		host.wr(4'hc, 8'h34);
		host.wr(4'hd, 8'h12);
		host.wr(4'he, 8'h56);
		host.wr(4'hf, 8'h02);
		chk(count0_r, 24'h561234);
		host.wr(4'hf, 8'h40);
		host.wr(4'hc, 8'haa);
		chk(count0_r, 24'h561234);
		rdc(4'hc, 8'h34);
		rdc(4'hd, 8'h12);
		rdc(4'he, 8'h56);
	endtask : t_load0
	// Load and latch counter 1
	task automatic t_load1;
		host.wr(4'hc, 8'hcd);
		host.wr(4'hd, 8'hab);
		host.wr(4'he, 8'hff);
		host.wr(4'hf, 8'h82);
		chk({8'h00, count1_r}, 24'h00abcd);
		chk(count0_r, 24'h561234);
		host.wr(4'hf, 8'hc0);
		rdc(4'hc, 8'hcd);
		rdc(4'hd, 8'hab);
		rdc(4'he, 8'h56);
	endtask : t_load1
	// Run, stop and gating
	task automatic t_count;
		host.wr(4'hf, 8'h04);
		pulse(1'b0, 3);
		chk(count0_r, 24'h561231);
		host.wr(4'hf, 8'h10);
		pulse(1'b0, 1);
		chk(count0_r, 24'h561231);
		gt0 <= 1'b1;
		pulse(1'b0, 1);
		chk(count0_r, 24'h561230);
		host.wr(4'hf, 8'h08);
		pulse(1'b0, 2);
		chk(count0_r, 24'h561230);
		host.wr(4'hf, 8'h84);
		host.wr(4'hf, 8'h90);
		pulse(1'b1, 2);
		chk({8'h00, count1_r}, 24'h00abcd);
		gt1 <= 1'b1;
		pulse(1'b1, 1);
		chk({8'h00, count1_r}, 24'h00abcc);
		host.wr(4'hf, 8'ha0);
		gt1 <= 1'b0;
		pulse(1'b1, 1);
		chk({8'h00, count1_r}, 24'h00abcb);
	endtask : t_count
	// Malformed command, clears, revision, unmapped
	task automatic t_misc;
		host.wr(4'hf, 8'h03);
		chk(count0_r, 24'h561230);
		host.wr(4'hf, 8'h01);
		chk(count0_r, 24'h000000);
		host.wr(4'hf, 8'h81);
		chk({8'h00, count1_r}, 24'h000000);
		rdc(4'hf, `DDCR_REVISION);
		rdc(4'h0, 8'h00);
	endtask : t_misc
	// Mid-run reset clears counters, snapshot and run enables
	task automatic t_reset;
		host.wr(4'hf, 8'h02);
		chk(count0_r, 24'hffabcd);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		chk(count0_r, 24'h000000);
		rdc(4'hc, 8'h00);
		pulse(1'b1, 1);
		chk({8'h00, count1_r}, 24'h000000);
	endtask : t_reset
	// Main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_load0();
		t_load1();
		t_count();
		t_misc();
		t_reset();
		finish_test();
	end
	// Watchdog
	initial begin
		#200000;
		err_count++;
		finish_test();
	end
endmodule : ddcr_top_tb
